// ---- core/reset_option_loader.sv ----
// Purpose: Loads watchdog options and bandgap reference from flash at every reset
// Assumes: Flash read port answers with flash_rvalid one or more cycles after flash_req
// Notes:   cpu_hold_n stays low until both words are captured
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module reset_option_loader
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             flash_req,
   output logic      [23:0] flash_addr,
   output logic             flash_abort,
   input  wire logic        flash_rvalid,
   input  wire logic [15:0] flash_rdata,
   output logic             cpu_hold_n,
   output logic      [2:0]  watchdog_rate_field,
   output logic             watchdog_window_bit,
   output logic      [11:0] bandgap_reference
);
   option_loader_pkg::load_state_e   state;
   option_loader_pkg::watchdog_cfg_s decoded;
   logic                             reload;
   logic                             access;
   logic                             write_done;

   option_decode u_decode
   (
      .option_byte (flash_rdata[7:0]),
      .cfg         (decoded)
   );

   assign access = psel && penable;
   // Writes act only at the edge where pready is seen high
   assign write_done = access && pready && pwrite;

   // Reload strobe lets software rerun the sequence without a full reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reload <= 1'b0;
      else
         reload <= write_done && (paddr == option_loader_pkg::REG_RELOAD) && pwdata[0]
                   && (state == option_loader_pkg::ST_DONE);
   end

   // Sequencer restarts from idle on any reset, so a pending read dies with it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= option_loader_pkg::ST_IDLE;
      else
         case (state)
            option_loader_pkg::ST_IDLE:   state <= option_loader_pkg::ST_OPT_RQ;
            option_loader_pkg::ST_OPT_RQ: state <= option_loader_pkg::ST_OPT_WT;
            option_loader_pkg::ST_OPT_WT: if (flash_rvalid) state <= option_loader_pkg::ST_BG_RQ;
            option_loader_pkg::ST_BG_RQ:  state <= option_loader_pkg::ST_BG_WT;
            option_loader_pkg::ST_BG_WT:  if (flash_rvalid) state <= option_loader_pkg::ST_DONE;
            option_loader_pkg::ST_DONE:   if (reload) state <= option_loader_pkg::ST_IDLE;
            default:                      state <= option_loader_pkg::ST_IDLE;
         endcase
   end

   // Flash request port
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flash_req  <= 1'b0;
         flash_addr <= 24'h00_0000;
      end
      else
      begin
         flash_req <= (state == option_loader_pkg::ST_IDLE) || (state == option_loader_pkg::ST_OPT_WT && flash_rvalid);
         if (state == option_loader_pkg::ST_IDLE)
            flash_addr <= option_loader_pkg::OPTION_ADDR;
         else if (state == option_loader_pkg::ST_OPT_WT && flash_rvalid)
            flash_addr <= option_loader_pkg::BANDGAP_ADDR;
      end
   end

   // Abort is held through reset and the first cycle after it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flash_abort <= 1'b1;
      else
         flash_abort <= 1'b0;
   end

   // Captured values
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_rate_field <= option_loader_pkg::RATE_RESET;
         watchdog_window_bit <= option_loader_pkg::WINDOW_RESET;
      end
      else if (state == option_loader_pkg::ST_OPT_WT && flash_rvalid)
      begin
         watchdog_rate_field <= decoded.watchdog_rate_field;
         watchdog_window_bit <= decoded.watchdog_window_bit;
      end
   end

   // Stored value is already the eight-sample mean; only the upper 12 bits carry data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bandgap_reference <= option_loader_pkg::BANDGAP_RESET;
      else if (state == option_loader_pkg::ST_BG_WT && flash_rvalid)
         bandgap_reference <= flash_rdata[15:4];
   end

   // Hold released only after both captures have landed
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cpu_hold_n <= 1'b0;
      else
         cpu_hold_n <= (state == option_loader_pkg::ST_DONE) && !reload;
   end

   // APB slave, one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= access && !pready;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (access && !pready)
         begin
            if (paddr == option_loader_pkg::REG_STATUS)
               prdata <= {30'h0, state != option_loader_pkg::ST_DONE, state == option_loader_pkg::ST_DONE};
            else if (paddr == option_loader_pkg::REG_WATCHDOG)
               prdata <= {28'h0, watchdog_window_bit, watchdog_rate_field};
            else if (paddr == option_loader_pkg::REG_BANDGAP)
               prdata <= {20'h0, bandgap_reference};
            else if (paddr == option_loader_pkg::REG_RELOAD)
               prdata <= 32'h0000_0000;
            else
               pslverr <= 1'b1;
         end
      end
   end

   chk_hold_until_done: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_hold_n |-> $past(state) == option_loader_pkg::ST_DONE)
      else $error("cpu released before load done");
   chk_rate_inverted: assert property (@(posedge pclk) disable iff (!presetn)
      (state == option_loader_pkg::ST_OPT_WT && flash_rvalid) |=> watchdog_rate_field == ~$past(flash_rdata[2:0]))
      else $error("rate not inverse of option");
   chk_window_inverted: assert property (@(posedge pclk) disable iff (!presetn)
      (state == option_loader_pkg::ST_OPT_WT && flash_rvalid) |=> watchdog_window_bit == ~$past(flash_rdata[3]))
      else $error("window not inverse of option");
   chk_option_fetch: assert property (@(posedge pclk) disable iff (!presetn)
      (state == option_loader_pkg::ST_OPT_RQ) |-> flash_req && flash_addr == option_loader_pkg::OPTION_ADDR)
      else $error("option fetch address wrong");
   chk_bandgap_fetch: assert property (@(posedge pclk) disable iff (!presetn)
      (state == option_loader_pkg::ST_BG_RQ) |-> flash_req && flash_addr == option_loader_pkg::BANDGAP_ADDR)
      else $error("bandgap fetch address wrong");
   chk_bandgap_justify: assert property (@(posedge pclk) disable iff (!presetn)
      (state == option_loader_pkg::ST_BG_WT && flash_rvalid) |=> bandgap_reference == $past(flash_rdata[15:4]))
      else $error("bandgap not left justified");
   chk_valid_before_release: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(cpu_hold_n) |-> $stable(watchdog_rate_field) && $stable(watchdog_window_bit))
      else $error("watchdog values changed at release");
   chk_abort_cleared: assert property (@(posedge pclk) disable iff (!presetn)
      flash_abort |=> !flash_abort ##1 !flash_abort)
      else $error("abort stuck");
   chk_hold_during_load: assert property (@(posedge pclk) disable iff (!presetn)
      (state != option_loader_pkg::ST_DONE) |=> !cpu_hold_n)
      else $error("cpu not held during load");
   chk_reload_when_done: assert property (@(posedge pclk) disable iff (!presetn)
      reload |-> $past(state) == option_loader_pkg::ST_DONE)
      else $error("reload accepted while busy");
   chk_rate_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (state == option_loader_pkg::ST_DONE && $past(state) == option_loader_pkg::ST_DONE)
      |-> $stable(watchdog_rate_field) && $stable(watchdog_window_bit))
      else $error("watchdog values moved after load");
   chk_req_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      flash_req |=> !flash_req)
      else $error("flash request longer than one cycle");
   chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_idle_prdata: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
   chk_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("slave error without ready");
   cov_load_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(cpu_hold_n));
   cov_slow_flash: cover property (@(posedge pclk) disable iff (!presetn)
      state == option_loader_pkg::ST_OPT_WT && !flash_rvalid);
   cov_window_off: cover property (@(posedge pclk) disable iff (!presetn)
      cpu_hold_n && !watchdog_window_bit);
   cov_reload: cover property (@(posedge pclk) disable iff (!presetn) reload);
   cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule // reset_option_loader
`default_nettype wire

// ---- include/option_loader_pkg.sv ----
// Purpose: Constants and carrier types for the reset option loader
// Assumes: 32-bit APB, 24-bit global flash addresses, byte-wide option fetch
// Notes:   Overview of operation
package option_loader_pkg;
   localparam logic [23:0] OPTION_ADDR      = 24'hff_fe0e;
   localparam logic [23:0] BANDGAP_ADDR     = 24'h1f_c040;
   localparam int          RATE_POS         = 0;
   localparam int          RATE_W           = 3;
   localparam int          WINDOW_POS       = 3;
   localparam logic [2:0]  RATE_RESET       = 3'h0;
   localparam logic        WINDOW_RESET     = 1'b0;
   localparam logic [11:0] BANDGAP_RESET    = 12'h000;
   localparam int          BANDGAP_SAMPLES  = 8;
   // APB register offsets (byte addresses)
   localparam logic [7:0]  REG_STATUS       = 8'h00;
   localparam logic [7:0]  REG_WATCHDOG     = 8'h04;
   localparam logic [7:0]  REG_BANDGAP      = 8'h08;
   localparam logic [7:0]  REG_RELOAD       = 8'h0c;
   localparam int          ST_DONE_POS      = 0;
   localparam int          ST_BUSY_POS      = 1;
   localparam int          WD_WINDOW_POS    = 3;

   typedef struct packed {
      logic [2:0] watchdog_rate_field;
      logic       watchdog_window_bit;
   } watchdog_cfg_s;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_OPT_RQ = 3'b001,
      ST_OPT_WT = 3'b010,
      ST_BG_RQ  = 3'b011,
      ST_BG_WT  = 3'b100,
      ST_DONE   = 3'b101
   } load_state_e;
endpackage

// ---- core/option_decode.sv ----
// Purpose: Turns the flash option byte into watchdog configuration
// Assumes: Pure combinational, same clock domain as caller
// Notes:   Both fields are stored inverted so erased flash yields the slowest, window-off setting
`timescale 1ns/1ps
`default_nettype none
module option_decode
(
   input  wire logic [7:0]                        option_byte,
   output var  option_loader_pkg::watchdog_cfg_s  cfg
);
   always_comb
   begin
      cfg.watchdog_rate_field = ~option_byte[option_loader_pkg::RATE_POS +: option_loader_pkg::RATE_W];
      cfg.watchdog_window_bit = ~option_byte[option_loader_pkg::WINDOW_POS];
   end
endmodule // option_decode
`default_nettype wire

// ---- testbench/flash_config_model.sv ----
// Purpose: Behavioural flash configuration memory answering the loader reads
// Assumes: One read at a time, answer after delay plus one edges
// Notes:   Data lines toggle when idle so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module flash_config_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        flash_req,
   input  wire logic [23:0] flash_addr,
   input  wire logic [7:0]  option_byte,
   input  wire logic [15:0] bandgap_word,
   input  wire logic [3:0]  delay,
   output logic             flash_rvalid,
   output logic      [15:0] flash_rdata
);
   logic [15:0] word = 16'h0;
   int          left = -1;
   initial flash_rvalid = 1'b0;
   initial flash_rdata = 16'h0;
   always @(posedge pclk)
   begin
      flash_rvalid <= 1'b0;
      flash_rdata  <= ~flash_rdata;
      if (!presetn)
         left = -1;
      else if (flash_req)
      begin
         word = (flash_addr === option_loader_pkg::OPTION_ADDR) ? {8'hff, option_byte} : bandgap_word;
         left = int'(delay);
      end
      else if (left == 0)
      begin
         flash_rvalid <= 1'b1;
         flash_rdata  <= word;
         left = -1;
      end
      else if (left > 0)
         left--;
   end
endmodule // flash_config_model
`default_nettype wire

// ---- testbench/test_reset_option_loader.sv ----
// Purpose: Self-checking bench for the reset option loader
// Assumes: Twenty MHz clock, random option and bandgap words
// Notes:   Every option code is loaded by reset and by reload
`timescale 1ns/1ps
`default_nettype none
module test_reset_option_loader;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, flash_req, flash_abort, flash_rvalid;
   logic        cpu_hold_n, watchdog_window_bit, e;
   logic [7:0]  paddr, opt;
   logic [31:0] pwdata, prdata, r, seed;
   logic [23:0] flash_addr;
   logic [15:0] flash_rdata, bg;
   logic [2:0]  watchdog_rate_field;
   logic [11:0] bandgap_reference;
   logic [3:0]  dly;
   int          bad_count, total_checks, n;
   reset_option_loader u_reset_option_loader (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_req(flash_req), .flash_addr(flash_addr), .flash_abort(flash_abort), .flash_rvalid(flash_rvalid),
      .flash_rdata(flash_rdata), .cpu_hold_n(cpu_hold_n), .watchdog_rate_field(watchdog_rate_field),
      .watchdog_window_bit(watchdog_window_bit), .bandgap_reference(bandgap_reference));
   flash_config_model u_flash_config_model (.pclk(pclk), .presetn(presetn), .flash_req(flash_req),
      .flash_addr(flash_addr), .option_byte(opt), .bandgap_word(bg), .delay(dly), .flash_rvalid(flash_rvalid),
      .flash_rdata(flash_rdata));
   always #25 pclk = ~pclk;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog process ends a wait that never answers
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic load_check();
      int k;
      k = 0;
      while (cpu_hold_n !== 1'b1 && k < 200)
      begin
         @(posedge pclk);
         k++;
      end
      chk(32'(k < 200), 1);
      chk(watchdog_rate_field, 3'h7 - opt[2:0]);
      chk(watchdog_window_bit, 32'((int'(opt) / 8) % 2 == 0));
      chk(bandgap_reference, 32'(int'(bg) / 16));
      apb(1'b0, option_loader_pkg::REG_WATCHDOG, 32'h0);
      chk(r, {28'h0, ~opt[3], 3'h7 - opt[2:0]});
      apb(1'b0, option_loader_pkg::REG_BANDGAP, 32'h0);
      chk(r, 32'(int'(bg) / 16));
      apb(1'b0, option_loader_pkg::REG_STATUS, 32'h0);
      chk(r, 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, e}, 1);
      chk(r, 0);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h0; pwdata = 32'h0;
      seed = 32'h212f; opt = 8'h0; bg = 16'h0; dly = 4'h0; bad_count = 0; total_checks = 0;
      for (int i = 0; i < 16; i++)
      begin
         opt = (xs() & 8'hf0) | 8'(i);
         bg  = 16'(xs());
         dly = 4'(xs() % 8);
         presetn <= 1'b0;
         repeat (5) @(posedge pclk);
         chk(flash_abort, 1);
         chk(cpu_hold_n, 0);
         presetn <= 1'b1;
         @(posedge pclk);
         load_check();
         opt = opt ^ 8'h0f;
         bg  = 16'(xs());
         apb(1'b1, option_loader_pkg::REG_RELOAD, 32'h1);
         n = 0;
         while (cpu_hold_n !== 1'b0 && n < 10)
         begin
            @(posedge pclk);
            n++;
         end
         chk(cpu_hold_n, 0);
         load_check();
         $display("test %0d done", i);
      end
      test_done();
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      test_done();
   end
endmodule // test_reset_option_loader
`default_nettype wire
